// ---- design/shp_defs.vh ----
// shared constants for the serial flash hold/pause front end
`ifndef SHP_DEFS_VH
`define SHP_DEFS_VH

`define SHP_CLK_PERIOD_NS 50
`define SHP_PROG_TIME_NS 1000000
`define SHP_PROG_CYCLES (`SHP_PROG_TIME_NS / `SHP_CLK_PERIOD_NS)
`define SHP_PROG_CNT_W 24
`define SHP_BYTE_W 8
`define SHP_FIFO_DEPTH 4
`define SHP_SINGLE_LAST 3'h7
`define SHP_QUAD_LAST 3'h1
`define SHP_IDLE_BYTE 8'hFF
`define SHP_SYNC_W 6
// idle pin levels for the synchroniser: select high, pause pin high
`define SHP_SYNC_RST 6'h21

`endif

// ---- design/shp_sync.v ----
// two-flop synchroniser for a group of asynchronous pin levels
module shp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // levels
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

// ---- design/shp_fifo.v ----
// small synchronous fifo with valid/ready on both sides
module shp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // fill side
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output reg in_ready_o,
  // drain side
  output reg [WIDTH-1:0] out_data_o,
  output reg out_valid_o,
  input wire out_ready_i
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  wire [AW:0] next_count;
  wire [AW-1:0] next_rd_ptr;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign next_rd_ptr = !pop ? rd_ptr : (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      // head is registered; a push into an empty fifo bypasses the array
      out_data_o <= (push && (wr_ptr == next_rd_ptr)) ? in_data_i : mem[next_rd_ptr];
      count <= next_count;
      in_ready_o <= (next_count != DEPTH);
      out_valid_o <= (next_count != {(AW+1){1'b0}});
    end
  end

endmodule

// ---- design/shp_hold_pause.v ----
// serial flash front end: hold/pause control, quad lane three reuse, byte streams
`include "shp_defs.vh"

// Overview of operation
// - while paused, serial clock edges and serial input data are ignored.
// - while paused, the serial output stays undriven.
// - pause starts only with chip select low and serial clock low.
// - pause freezes shifting state; no deselect, no interface reset.
// - self-timed program or erase cycle keeps running through a pause.
// - quad program samples lanes three to zero on each rising clock edge.
// - quad read drives lanes three to zero on each falling clock edge.
// - select falling starts, rising ends; deselected ignores input, floats output.
// - modes 0 and 3: sample on rising edge, drive on falling edge.
module shp_hold_pause #(
  parameter PROG_CYCLES = `SHP_PROG_CYCLES,
  parameter FIFO_DEPTH = `SHP_FIFO_DEPTH
) (
  // clock and reset
  input wire CLK_SYS_I,
  input wire RST_N_I,
  // spi pins
  input wire CS_N_I,
  input wire SCK_I,
  input wire SI_I,
  output reg SI_O,
  output reg SI_OE_O,
  input wire SO_I,
  output reg SO_O,
  output reg SO_OE_O,
  input wire WP_I,
  output reg WP_O,
  output reg WP_OE_O,
  input wire QUAD_LANE_THREE_I,
  output reg QUAD_LANE_THREE_O,
  output reg QUAD_LANE_THREE_OE_O,
  // phase controls from the command decoder
  input wire QUAD_IN_I,
  input wire READ_OUT_I,
  input wire QUAD_OUT_I,
  // received bytes
  output wire [`SHP_BYTE_W-1:0] RX_DATA_O,
  output wire RX_VALID_O,
  input wire RX_READY_I,
  output reg RX_ROOM_O,
  output reg RX_OVERRUN_O,
  // bytes to send
  input wire [`SHP_BYTE_W-1:0] TX_DATA_I,
  input wire TX_VALID_I,
  output reg TX_READY_O,
  // status
  output reg HOLD_ACTIVE_O,
  output reg SELECTED_O,
  // self-timed cycle
  input wire PROG_START_I,
  output reg PROG_BUSY_O
);

  // fifo depth of two or more; its pointers are sized from it
  localparam FIFO_AW = $clog2(FIFO_DEPTH);

  wire [`SHP_SYNC_W-1:0] pins_sync;
  wire cs_n_s;
  wire sck_s;
  wire si_s;
  wire so_s;
  wire wp_s;
  wire lane3_s;
  reg sck_d;
  reg cs_n_d;
  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;
  wire selected;
  reg hold;
  wire pause_req;
  wire quad_any;
  reg [`SHP_BYTE_W-1:0] in_sh;
  reg [2:0] in_cnt;
  reg [`SHP_BYTE_W-1:0] pend_byte;
  reg pend_valid;
  wire fifo_in_ready;
  reg [`SHP_BYTE_W-1:0] out_sh;
  reg [2:0] out_left;
  reg [`SHP_BYTE_W-1:0] tx_buf;
  reg tx_buf_valid;
  reg [`SHP_PROG_CNT_W-1:0] prog_cnt;
  reg [`SHP_BYTE_W-1:0] next_in_sh;
  reg next_in_done;
  reg [`SHP_BYTE_W-1:0] next_cur;
  reg next_load;

  // pins from the host are asynchronous to the system clock
  // reset to idle levels so release shows no false select or pause
  shp_sync #(
    .WIDTH(`SHP_SYNC_W),
    .RST_VAL(`SHP_SYNC_RST)
  ) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .async_i({CS_N_I, SCK_I, SI_I, SO_I, WP_I, QUAD_LANE_THREE_I}),
    .sync_o(pins_sync)
  );

  assign cs_n_s = pins_sync[5];
  assign sck_s = pins_sync[4];
  assign si_s = pins_sync[3];
  assign so_s = pins_sync[2];
  assign wp_s = pins_sync[1];
  assign lane3_s = pins_sync[0];

  assign sck_rise = sck_s && !sck_d;
  assign sck_fall = !sck_s && sck_d;
  assign cs_fall = !cs_n_s && cs_n_d;
  assign cs_rise = cs_n_s && !cs_n_d;
  assign selected = !cs_n_s;
  // in quad phases the pin is data, so no pause can be read from it
  assign quad_any = QUAD_IN_I || (READ_OUT_I && QUAD_OUT_I);
  // a floating pin reads high through its pull-up, so no pause
  assign pause_req = !lane3_s && !quad_any;

  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sck_d <= sck_s;
      cs_n_d <= cs_n_s;
    end
  end

  // pause enters, and leaves on pin release, only while the clock is low
  // select high drops a pause, so a new frame never starts paused
  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hold <= 1'b0;
    end else if (!selected) begin
      hold <= 1'b0;
    end else if (!hold && pause_req && !sck_s) begin
      hold <= 1'b1;
    end else if (hold && !pause_req && !sck_s) begin
      hold <= 1'b0;
    end
  end

  // input sampling: one bit single, one nibble quad, msb first
  always @* begin
    next_in_sh = in_sh;
    next_in_done = 1'b0;
    if (QUAD_IN_I) begin
      next_in_sh = {in_sh[3:0], lane3_s, wp_s, so_s, si_s};
      next_in_done = (in_cnt == `SHP_QUAD_LAST);
    end else begin
      next_in_sh = {in_sh[6:0], si_s};
      next_in_done = (in_cnt == `SHP_SINGLE_LAST);
    end
  end

  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      in_sh <= {`SHP_BYTE_W{1'b0}};
      in_cnt <= 3'h0;
      pend_byte <= {`SHP_BYTE_W{1'b0}};
      pend_valid <= 1'b0;
      RX_OVERRUN_O <= 1'b0;
    end else begin
      if (pend_valid && fifo_in_ready) begin
        pend_valid <= 1'b0;
      end
      if (cs_fall) begin
        in_cnt <= 3'h0;
        RX_OVERRUN_O <= 1'b0;
      end else if (cs_rise) begin
        in_cnt <= 3'h0;
      end else if (selected && !hold && sck_rise) begin
        in_sh <= next_in_sh;
        in_cnt <= next_in_done ? 3'h0 : in_cnt + 3'h1;
        if (next_in_done) begin
          // a new byte is lost while the last one still waits for room; the select-fall clear wins
          if (pend_valid && !fifo_in_ready) begin
            RX_OVERRUN_O <= 1'b1;
          end else begin
            pend_byte <= next_in_sh;
            pend_valid <= 1'b1;
          end
        end
      end
    end
  end

  shp_fifo #(
    .WIDTH(`SHP_BYTE_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rx_fifo (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .in_data_i(pend_byte),
    .in_valid_i(pend_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(RX_DATA_O),
    .out_valid_o(RX_VALID_O),
    .out_ready_i(RX_READY_I)
  );

  // output shifting: new byte taken when previous is exhausted
  always @* begin
    next_load = (out_left == 3'h0);
    if (!next_load) begin
      next_cur = out_sh;
    end else if (tx_buf_valid) begin
      next_cur = tx_buf;
    end else begin
      next_cur = `SHP_IDLE_BYTE;
    end
  end

  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      out_sh <= {`SHP_BYTE_W{1'b0}};
      out_left <= 3'h0;
      tx_buf <= {`SHP_BYTE_W{1'b0}};
      tx_buf_valid <= 1'b0;
      TX_READY_O <= 1'b0;
      SI_O <= 1'b0;
      SO_O <= 1'b0;
      WP_O <= 1'b0;
      QUAD_LANE_THREE_O <= 1'b0;
    end else begin
      // one-byte buffer: ready returns one clock after the shifter takes it
      TX_READY_O <= !tx_buf_valid && !(TX_VALID_I && TX_READY_O);
      if (TX_VALID_I && TX_READY_O) begin
        tx_buf <= TX_DATA_I;
        tx_buf_valid <= 1'b1;
      end
      if (cs_fall || cs_rise) begin
        out_left <= 3'h0;
      end else if (selected && !hold && READ_OUT_I && sck_fall) begin
        if (next_load && tx_buf_valid) begin
          tx_buf_valid <= 1'b0;
        end
        if (QUAD_OUT_I) begin
          {QUAD_LANE_THREE_O, WP_O, SO_O, SI_O} <= next_cur[7:4];
          out_sh <= {next_cur[3:0], 4'h0};
          out_left <= next_load ? `SHP_QUAD_LAST : out_left - 3'h1;
        end else begin
          SO_O <= next_cur[7];
          out_sh <= {next_cur[6:0], 1'b0};
          out_left <= next_load ? `SHP_SINGLE_LAST : out_left - 3'h1;
        end
      end
    end
  end

  // drivers: none while deselected or paused
  // lane three stays driven in quad read: the pin is data there
  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SI_OE_O <= 1'b0;
      SO_OE_O <= 1'b0;
      WP_OE_O <= 1'b0;
      QUAD_LANE_THREE_OE_O <= 1'b0;
    end else begin
      SO_OE_O <= selected && !hold && READ_OUT_I;
      SI_OE_O <= selected && !hold && READ_OUT_I && QUAD_OUT_I;
      WP_OE_O <= selected && !hold && READ_OUT_I && QUAD_OUT_I;
      QUAD_LANE_THREE_OE_O <= selected && READ_OUT_I && QUAD_OUT_I;
    end
  end

  // self-timed cycle never looks at hold or select
  // a start while busy is ignored, not queued
  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prog_cnt <= {`SHP_PROG_CNT_W{1'b0}};
      PROG_BUSY_O <= 1'b0;
    end else if (PROG_BUSY_O) begin
      prog_cnt <= prog_cnt - 1'b1;
      if (prog_cnt == {{(`SHP_PROG_CNT_W-1){1'b0}}, 1'b1}) begin
        PROG_BUSY_O <= 1'b0;
      end
    end else if (PROG_START_I) begin
      prog_cnt <= PROG_CYCLES[`SHP_PROG_CNT_W-1:0];
      PROG_BUSY_O <= 1'b1;
    end
  end

  // registered copies so every status pin leaves a flop
  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RX_ROOM_O <= 1'b0;
      HOLD_ACTIVE_O <= 1'b0;
      SELECTED_O <= 1'b0;
    end else begin
      RX_ROOM_O <= fifo_in_ready && !pend_valid;
      HOLD_ACTIVE_O <= hold;
      SELECTED_O <= selected;
    end
  end

endmodule

// ---- verif/shp_hold_pause_asserts.sv ----
// assertions on the hold/pause front end ports
module shp_chk #(
  parameter PROG_CYCLES = 8
) (
  // clock and reset
  input wire CLK_SYS_I,
  input wire RST_N_I,
  // pins and status
  input wire CS_N_I,
  input wire SCK_I,
  input wire QUAD_LANE_THREE_I,
  input wire QUAD_IN_I,
  input wire READ_OUT_I,
  input wire QUAD_OUT_I,
  input wire SO_OE_O,
  input wire QUAD_LANE_THREE_OE_O,
  input wire HOLD_ACTIVE_O,
  input wire SELECTED_O,
  input wire PROG_START_I,
  input wire PROG_BUSY_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  int busy_cnt;
  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I)
      busy_cnt <= 0;
    else
      busy_cnt <= PROG_BUSY_O ? busy_cnt + 1 : 0;
  end
  property p_hold_float; HOLD_ACTIVE_O && $past(HOLD_ACTIVE_O, 3) |-> !SO_OE_O; endproperty
  a_hold_float: assert property (p_hold_float) else $error("so driven in pause");
  property p_desel_float; CS_N_I[*5] |-> !SO_OE_O && !QUAD_LANE_THREE_OE_O; endproperty
  a_desel_float: assert property (p_desel_float) else $error("driven deselected");
  property p_hold_start;
    $rose(HOLD_ACTIVE_O) |-> SELECTED_O && !$past(QUAD_LANE_THREE_I, 2) && !$past(SCK_I, 2);
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("bad pause start");
  property p_hold_end;
    $fell(HOLD_ACTIVE_O) |-> $past(QUAD_LANE_THREE_I, 2) || $past(CS_N_I, 2);
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("bad pause end");
  property p_no_quad_pause; QUAD_IN_I && !HOLD_ACTIVE_O |=> !HOLD_ACTIVE_O; endproperty
  a_no_quad_pause: assert property (p_no_quad_pause) else $error("pause in quad");
  property p_lane3_in; (!READ_OUT_I)[*5] |-> !QUAD_LANE_THREE_OE_O; endproperty
  a_lane3_in: assert property (p_lane3_in) else $error("lane three driven");
  property p_quad_drive;
    (READ_OUT_I && QUAD_OUT_I && !CS_N_I)[*5] |-> QUAD_LANE_THREE_OE_O;
  endproperty
  a_quad_drive: assert property (p_quad_drive) else $error("lane three idle");
  property p_prog_len; $fell(PROG_BUSY_O) |-> busy_cnt == PROG_CYCLES; endproperty
  a_prog_len: assert property (p_prog_len) else $error("busy length");
  property p_prog_start; $rose(PROG_BUSY_O) |-> $past(PROG_START_I, 2) || $past(PROG_START_I); endproperty
  a_prog_start: assert property (p_prog_start) else $error("busy unasked");
  property p_sel; $stable(CS_N_I)[*5] |-> SELECTED_O == !CS_N_I; endproperty
  a_sel: assert property (p_sel) else $error("select state");
endmodule
bind shp_hold_pause shp_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (.CLK_SYS_I, .RST_N_I,
  .CS_N_I, .SCK_I, .QUAD_LANE_THREE_I, .QUAD_IN_I, .READ_OUT_I, .QUAD_OUT_I, .SO_OE_O,
  .QUAD_LANE_THREE_OE_O, .HOLD_ACTIVE_O, .SELECTED_O, .PROG_START_I, .PROG_BUSY_O);

// ---- verif/shp_host.sv ----
// spi host model: select, serial clock, four lanes and the pause pin
module shp_host (
  // lanes seen from the device
  input wire [3:0] oe,
  input wire [3:0] dq_o,
  output wire [3:0] dq_i,
  // select and clock
  output logic cs_n,
  output logic sck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hv = 4'h0;
  logic [3:0] hen = 4'h0;
  logic pause_n = 1'b1;
  // released lanes toggle so no stale bit passes; lane three pulled up
  assign dq_i = (oe & dq_o) | (~oe & hen & hv) | (~oe & ~hen & {pause_n, {3{~sck}}});
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
  end
  task automatic sel(input logic idle);
    sck = idle;
    #200 cs_n = 1'b0;
    #200;
  endtask
  task automatic desel(input logic idle);
    hen = 4'h0;
    #200 sck = idle;
    #200 cs_n = 1'b1;
    #400;
  endtask
  // one byte msb first; a pause with junk clocks goes in before bit hp
  task automatic xfer(input logic [7:0] tx, input bit quad, input bit drv, input int hp,
    output logic [7:0] rx);
    logic [3:0] s;
    rx = 8'h00;
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      sck = 1'b0;
      hen = drv ? (quad ? 4'hF : 4'h1) : 4'h0;
      hv = quad ? tx[7-4*i -: 4] : {3'h0, tx[7-i]};
      if (i == hp) begin
        s = hv;
        #200 pause_n = 1'b0;
        repeat (3) begin
          #200 sck = 1'b1;
          hv = ~hv;
          #200 sck = 1'b0;
        end
        hv = s;
        pause_n = 1'b1;
      end
      #200 sck = 1'b1;
      #100 rx = quad ? {rx[3:0], dq_i} : {rx[6:0], dq_i[1]};
      #100;
    end
  endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the hold/pause front end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic quad_in = 1'b0, read_out = 1'b0, quad_out = 1'b0, stall = 1'b0;
  logic rx_ready = 1'b0, tx_valid = 1'b0, prog_start = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [31:0] seed = 32'hCDB836A5;
  logic [7:0] exp_q[$], got_q[$];
  int errors = 0, tests_run = 0;
  wire [3:0] oe, dq_o, dq_i;
  wire [7:0] rx_data;
  wire cs_n, sck, rx_valid, rx_room, rx_ovr, tx_ready, hold_act, prog_busy, sel_st;
  shp_hold_pause #(.PROG_CYCLES(8)) dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .SCK_I(sck),
    .SI_I(dq_i[0]), .SI_O(dq_o[0]), .SI_OE_O(oe[0]),
    .SO_I(dq_i[1]), .SO_O(dq_o[1]), .SO_OE_O(oe[1]),
    .WP_I(dq_i[2]), .WP_O(dq_o[2]), .WP_OE_O(oe[2]),
    .QUAD_LANE_THREE_I(dq_i[3]), .QUAD_LANE_THREE_O(dq_o[3]),
    .QUAD_LANE_THREE_OE_O(oe[3]), .QUAD_IN_I(quad_in), .READ_OUT_I(read_out),
    .QUAD_OUT_I(quad_out), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
    .RX_READY_I(rx_ready), .RX_ROOM_O(rx_room), .RX_OVERRUN_O(rx_ovr),
    .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready),
    .HOLD_ACTIVE_O(hold_act), .SELECTED_O(sel_st), .PROG_START_I(prog_start),
    .PROG_BUSY_O(prog_busy));
  shp_host h (.oe(oe), .dq_o(dq_o), .dq_i(dq_i), .cs_n(cs_n), .sck(sck));
  initial forever #25 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // consumer stalls at random; byte order checked against the queue
  always @(negedge clk) rx_ready <= !stall && (rnd() > 8'h50);
  always @(posedge clk) if (rx_valid === 1'b1 && rx_ready) got_q.push_back(rx_data);
  // a program cycle is started inside every pause and timed
  initial forever begin
    logic [7:0] c;
    @(posedge hold_act);
    @(negedge clk);
    prog_start = 1'b1;
    @(negedge clk);
    prog_start = 1'b0;
    c = 8'h00;
    repeat (2) if (prog_busy !== 1'b1) @(negedge clk);
    while (prog_busy === 1'b1 && c < 8'hF0) begin
      c++;
      @(negedge clk);
    end
    chk(c, 8'h08);
  end
  task automatic wr(input int n, input bit quad, input logic idle, input int hp);
    logic [7:0] b, r;
    @(negedge clk);
    quad_in = quad;
    h.sel(idle);
    for (int k = 0; k < n; k++) begin
      b = (k < 2) ? {8{k[0]}} : rnd();
      exp_q.push_back(b);
      h.xfer(b, quad, 1'b1, (k == 1) ? hp : -1, r);
    end
    h.desel(idle);
    @(negedge clk);
    quad_in = 1'b0;
  endtask
  task automatic drain();
    @(negedge clk);
    stall = 1'b0;
    repeat (60) @(negedge clk);
    chk(8'(got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[k]) chk(got_q[k], exp_q[k]);
    got_q.delete();
    exp_q.delete();
  endtask
  task automatic send(input logic [7:0] b);
    while (tx_ready !== 1'b1) @(negedge clk);
    tx_data = b;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  task automatic rd(input int n, input bit quad, input int hp);
    logic [7:0] r;
    logic [7:0] q[$];
    for (int k = 0; k < n; k++) q.push_back(k ? rnd() : 8'h0F);
    @(negedge clk);
    read_out = 1'b1;
    quad_out = quad;
    fork
      foreach (q[k]) send(q[k]);
      begin
        h.sel(1'b1);
        for (int k = 0; k < n; k++) begin
          h.xfer(8'h00, quad, 1'b0, (k == 1) ? hp : -1, r);
          chk(r, q[k]);
        end
        chk({7'h0, sel_st}, 8'h01);
        h.desel(1'b1);
      end
    join
    @(negedge clk);
    read_out = 1'b0;
    quad_out = 1'b0;
    repeat (20) @(negedge clk);
    got_q.delete();
  endtask
  initial begin
    #500000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    for (int m = 0; m < 4; m++) begin
      wr(4, m[1], m[0], m[1] ? -1 : 3);
      drain();
    end
    rd(3, 1'b0, 2);
    rd(3, 1'b1, -1);
    h.pause_n = 1'b0;
    repeat (10) @(negedge clk);
    chk({7'h0, hold_act}, 8'h00);
    chk({7'h0, sel_st}, 8'h00);
    h.pause_n = 1'b1;
    stall = 1'b1;
    wr(6, 1'b0, 1'b1, -1);
    chk({7'h0, rx_room}, 8'h00);
    chk({7'h0, rx_ovr}, 8'h01);
    void'(exp_q.pop_back());
    drain();
    wr(1, 1'b0, 1'b0, -1);
    chk({7'h0, rx_ovr}, 8'h00);
    drain();
    wrap_up();
  end
endmodule
